// ### hdl/pefc_cmd_core.v
// Summary of operation
// - Config bits 7:5 read back as zero
// - Policy clear: run whenever input power present
// - Policy set: pin and/or run command decide
// - Software bit selects honouring run command
// - Pin-use bit selects pin, gates lockout function
// - Polarity bit: 0 active low, 1 high
// - Delay bit 0: hold, then ramp down
// - Delay bit 1: pin off stops at once
// - Enable/lockout pin is the control input
// - Bad config write rejected, flagged, alerted
// - Data-less fault clear clears addressed status
// - Fault clear releases the alert output
// - Fault clear never restarts latched-off unit
// - Persisting fault sets again and alerts
// - Alert response releases alert, keeps status
// - Pre-response faults blocked until cleared
// - Phase selector applies to later fault clears only
// - Phased commands refused before phase setup
// - Grounded strap takes phase zero
// - Follower takes phase from stagger position
// - Selector resets all-phases; phases NPH and up, other than all-phases, invalid
// - Run command top bit turns on
`timescale 1ns/10ps
`default_nettype none
`include "pefc_consts.vh"

module pefc_cmd_core #(
  parameter SW  = 8,
  parameter NPH = 4,
  parameter CW  = 16
) (
  input  wire          clk,
  input  wire          arst_n,
  input  wire          cmd_valid,
  input  wire [7:0]    cmd_code,
  input  wire          cmd_read,
  input  wire          cmd_has_data,
  input  wire [7:0]    cmd_wdata,
  input  wire          ara_read,
  output reg           rsp_valid,
  output reg           rsp_ack,
  output reg  [7:0]    rsp_rdata,
  input  wire [7:0]    run_cmd,
  input  wire          enable_lockout_pin,
  input  wire          power_present,
  input  wire          phase_ready,
  input  wire          sense_return_follower_strap,
  input  wire [7:0]    stagger_position_config,
  input  wire [CW-1:0] turn_off_hold_time,
  input  wire [CW-1:0] turn_off_ramp_time,
  input  wire [SW-1:0] fault_src,
  input  wire          fault_latch_off,
  output reg           convert_en,
  output reg           ramp_down,
  output reg           lockout_active,
  output reg           smbalert_n,
  output reg  [SW-1:0] status,
  output reg           cml_invalid,
  output reg           phase_selected,
  output reg  [7:0]    my_phase
);

  // ***************************************************
  // State
  // ***************************************************
  reg  [4:0]    cfg;
  reg  [7:0]    phase_sel;
  reg           en_s1;
  reg           en_s2;
  reg           strap_done;
  reg           latched;
  reg           want_q;
  reg  [SW:0]   block;
  reg  [3:0]    state;
  reg  [3:0]    next_state;
  reg  [CW-1:0] cnt;
  reg  [CW-1:0] next_cnt;
  reg           want;
  reg           clr_q;

  localparam [3:0] ST_OFF  = 4'h1;
  localparam [3:0] ST_RUN  = 4'h2;
  localparam [3:0] ST_HOLD = 4'h4;
  localparam [3:0] ST_RAMP = 4'h8;
  wire          cfg_pu;
  wire          cfg_cmd;
  wire          cfg_cp;
  wire          cfg_pol;
  wire          cfg_dly;

  assign cfg_pu  = cfg[`PEFC_CFG_PU];
  assign cfg_cmd = cfg[`PEFC_CFG_CMD];
  assign cfg_cp  = cfg[`PEFC_CFG_CP];
  assign cfg_pol = cfg[`PEFC_CFG_POL];
  assign cfg_dly = cfg[`PEFC_CFG_DLY];

  // ***************************************************
  // Pin synchroniser
  // ***************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
    end else begin
      en_s1 <= enable_lockout_pin;
      en_s2 <= en_s1;
    end
  end

  // ***************************************************
  // Command decode
  // ***************************************************
  wire       is_wr;
  wire       is_rd;
  wire       hit_cfg;
  wire       hit_clr;
  wire       hit_ph;
  wire       cfg_ok;
  wire       cfg_bad;
  wire       clr_ok;
  wire       clr_bad;
  wire       ph_val;
  wire       ph_ok;
  wire       ph_bad;
  wire       rd_bad;
  wire       addr_me;
  wire       clr_me;
  wire       any_bad;

  assign is_wr   = cmd_valid & ~cmd_read;
  assign is_rd   = cmd_valid & cmd_read;
  assign hit_cfg = (cmd_code == `PEFC_CMD_ONOFF);
  assign hit_clr = (cmd_code == `PEFC_CMD_CLEAR);
  assign hit_ph  = (cmd_code == `PEFC_CMD_PHASE);

  // Upper bits must be zero for a listed value
  assign cfg_ok  = is_wr & hit_cfg & cmd_has_data &
                   (cmd_wdata[`PEFC_CFG_RSV_MSB:`PEFC_CFG_RSV_LSB] == `PEFC_CFG_RSV_VAL);
  assign cfg_bad = is_wr & hit_cfg & ~cfg_ok;

  assign clr_ok  = is_wr & hit_clr & ~cmd_has_data & phase_ready;
  assign clr_bad = is_wr & hit_clr & ~clr_ok;

  assign ph_val  = (cmd_wdata == `PEFC_PHASE_ALL) |
                   ({24'h000000, cmd_wdata} < NPH);
  assign ph_ok   = is_wr & hit_ph & cmd_has_data & ph_val;
  assign ph_bad  = is_wr & hit_ph & ~ph_ok;

  assign rd_bad  = is_rd & hit_clr;

  assign any_bad = cfg_bad | clr_bad | ph_bad | rd_bad;

  // This unit is one phase of the stack
  assign addr_me = (phase_sel == `PEFC_PHASE_ALL) |
                   (phase_sel == my_phase);
  assign clr_me  = clr_ok & addr_me;

  // ***************************************************
  // Configuration and phase registers
  // ***************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg       <= `PEFC_CFG_RST;
      phase_sel <= `PEFC_PHASE_RST;
    end else begin
      if (cfg_ok) begin
        cfg <= cmd_wdata[4:0];
      end
      if (ph_ok) begin
        phase_sel <= cmd_wdata;
      end
    end
  end

  // ***************************************************
  // Strap capture after reset release
  // ***************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_done <= 1'b0;
      my_phase   <= `PEFC_PHASE_LEADER;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      if (sense_return_follower_strap) begin
        my_phase <= stagger_position_config;
      end else begin
        my_phase <= `PEFC_PHASE_LEADER;
      end
    end
  end

  // ***************************************************
  // Enable source combination
  // ***************************************************
  wire pin_on;
  wire pin_off;
  wire go;
  wire toggle_on;

  assign pin_on  = cfg_pol ? en_s2 : ~en_s2;
  assign pin_off = cfg_pu & cfg_cp & ~pin_on;

  always @* begin
    want = 1'b0;
    if (!cfg_pu) begin
      want = power_present;
    end else begin
      want = power_present &
             (~cfg_cmd | run_cmd[`PEFC_RUN_ON_BIT]) &
             (~cfg_cp | pin_on);
    end
  end

  assign go        = want & ~latched;
  assign toggle_on = want & ~want_q;

  // Fault clear leaves this untouched; only an off request or loss of input power frees it
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latched <= 1'b0;
      want_q  <= 1'b0;
    end else begin
      want_q <= want;
      if (fault_latch_off) begin
        latched <= 1'b1;
      end else if (!want) begin
        latched <= 1'b0;
      end
    end
  end

  // ***************************************************
  // Turn-off sequencer
  // ***************************************************
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_OFF: begin
        if (go) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!go) begin
          if (pin_off & ~cfg_dly & ~latched & power_present) begin
            next_state = ST_HOLD;
            next_cnt   = turn_off_hold_time;
          end else begin
            next_state = ST_OFF;
          end
        end
      end
      ST_HOLD: begin
        if (latched | ~power_present) begin
          next_state = ST_OFF;
        end else if (go) begin
          next_state = ST_RUN;
        end else if (cnt <= {{(CW-1){1'b0}}, 1'b1}) begin
          next_state = ST_RAMP;
          next_cnt   = turn_off_ramp_time;
        end else begin
          next_cnt = cnt - {{(CW-1){1'b0}}, 1'b1};
        end
      end
      ST_RAMP: begin
        if (latched | ~power_present) begin
          next_state = ST_OFF;
        end else if (cnt <= {{(CW-1){1'b0}}, 1'b1}) begin
          next_state = ST_OFF;
        end else begin
          next_cnt = cnt - {{(CW-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        next_state = ST_OFF;
        next_cnt   = {CW{1'b0}};
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state          <= ST_OFF;
      cnt            <= {CW{1'b0}};
      convert_en     <= 1'b0;
      ramp_down      <= 1'b0;
      lockout_active <= 1'b0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      convert_en     <= (next_state != ST_OFF);
      ramp_down      <= (next_state == ST_RAMP);
      lockout_active <= cfg_pu & cfg_cp & cfg_pol;
    end
  end

  // ***************************************************
  // Status, alert and alert response
  // ***************************************************
  wire          clr_all;
  wire [SW:0]   stat_all;
  wire [SW:0]   set_all;
  wire [SW:0]   rise;
  wire          new_evt;

  assign clr_all  = clr_me | toggle_on;
  assign stat_all = {cml_invalid, status};
  assign set_all  = {any_bad, fault_src};
  // Bits cleared last cycle and still present alert again
  assign rise     = set_all & (~stat_all | {(SW+1){clr_q}});
  assign new_evt  = |(rise & ~block);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status      <= {SW{1'b0}};
      cml_invalid <= 1'b0;
      block       <= {(SW+1){1'b0}};
      smbalert_n  <= 1'b1;
      clr_q       <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      status      <= (status & ~{SW{clr_all}}) | fault_src;
      cml_invalid <= (cml_invalid & ~clr_all) | any_bad;
      clr_q       <= clr_all;
      if (clr_all) begin
        block <= {(SW+1){1'b0}};
      end else if (ara_read) begin
        block <= stat_all | set_all;
      end
      if (new_evt) begin
        smbalert_n <= 1'b0;
      end else if (ara_read | clr_me) begin
        smbalert_n <= 1'b1;
      end
    end
  end

  // ***************************************************
  // Response
  // ***************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid      <= 1'b0;
      rsp_ack        <= 1'b0;
      rsp_rdata      <= 8'h00;
      phase_selected <= 1'b1;
    end else begin
      rsp_valid      <= cmd_valid;
      rsp_ack        <= cfg_ok | clr_ok | ph_ok |
                        (is_rd & (hit_cfg | hit_ph));
      rsp_rdata      <= 8'h00;
      phase_selected <= addr_me;
      if (is_rd & hit_cfg) begin
        rsp_rdata <= {`PEFC_CFG_RSV_VAL, cfg};
      end else if (is_rd & hit_ph) begin
        rsp_rdata <= phase_sel;
      end
    end
  end

endmodule

`default_nettype wire

// ### hdl/pefc_consts.vh
`ifndef PEFC_CONSTS_VH
`define PEFC_CONSTS_VH

// ***************************************************
// Command codes
// ***************************************************
`define PEFC_CMD_ONOFF      8'h02
`define PEFC_CMD_CLEAR      8'h03
`define PEFC_CMD_PHASE      8'h04

// ***************************************************
// Enable source configuration fields
// ***************************************************
`define PEFC_CFG_RSV_MSB    7
`define PEFC_CFG_RSV_LSB    5
`define PEFC_CFG_PU         4
`define PEFC_CFG_CMD        3
`define PEFC_CFG_CP         2
`define PEFC_CFG_POL        1
`define PEFC_CFG_DLY        0
`define PEFC_CFG_RSV_VAL    3'h0
`define PEFC_CFG_RST        5'h17

// ***************************************************
// Phase selector values
// ***************************************************
`define PEFC_PHASE_ALL      8'hFF
`define PEFC_PHASE_RST      8'hFF
`define PEFC_PHASE_LEADER   8'h00

// ***************************************************
// Run command field
// ***************************************************
`define PEFC_RUN_ON_BIT     7

`endif

// ### tb/pefc_cmd_core_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pefc_cmd_core_checker #(
  parameter SW  = 8,
  parameter NPH = 4
) (
  input wire logic          clk,
  input wire logic          arst_n,
  input wire logic          cmd_valid,
  input wire logic [7:0]    cmd_code,
  input wire logic          cmd_read,
  input wire logic          cmd_has_data,
  input wire logic [7:0]    cmd_wdata,
  input wire logic          ara_read,
  input wire logic          rsp_ack,
  input wire logic [7:0]    rsp_rdata,
  input wire logic          phase_ready,
  input wire logic          phase_selected,
  input wire logic [SW-1:0] fault_src,
  input wire logic          smbalert_n,
  input wire logic [SW-1:0] status,
  input wire logic          cml_invalid,
  input wire logic          lockout_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr(c);
    cmd_valid && cmd_code == c && !cmd_read && cmd_has_data;
  endsequence
  sequence s_clr;
    cmd_valid && cmd_code == 8'h03 && !cmd_read && !cmd_has_data && phase_ready && phase_selected && !ara_read;
  endsequence
  property p_rsvd;
    cmd_valid && cmd_code == 8'h02 && cmd_read |=> rsp_rdata[7:5] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_bad_cfg;
    s_wr(8'h02) ##0 cmd_wdata[7:5] != 3'h0 |=> !rsp_ack && cml_invalid;
  endproperty
  a_bad_cfg: assert property (p_bad_cfg) else $error("bad config taken");
  property p_lock;
    s_wr(8'h02) ##0 cmd_wdata[7:5] == 3'h0 ##1 !cmd_valid |=>
      lockout_active == $past(cmd_wdata[4] & cmd_wdata[2] & cmd_wdata[1], 2);
  endproperty
  a_lock: assert property (p_lock) else $error("lockout wrong");
  property p_bad_ph;
    s_wr(8'h04) ##0 cmd_wdata != 8'hFF && cmd_wdata >= NPH |=> !rsp_ack && cml_invalid;
  endproperty
  a_bad_ph: assert property (p_bad_ph) else $error("bad phase taken");
  property p_clr_rel;
    s_clr ##0 $stable(fault_src) |=> smbalert_n;
  endproperty
  a_clr_rel: assert property (p_clr_rel) else $error("alert kept");
  property p_clr_st;
    s_clr ##1 $stable(fault_src) |-> status == fault_src;
  endproperty
  a_clr_st: assert property (p_clr_st) else $error("status not cleared");
  property p_persist;
    s_clr ##0 fault_src != 0 ##1 $stable(fault_src) && !ara_read |=> !smbalert_n;
  endproperty
  a_persist: assert property (p_persist) else $error("no alert again");
  property p_ara;
    ara_read && !$past(cmd_valid) && $stable(fault_src) && $past(fault_src) == $past(fault_src, 2) |=>
      smbalert_n && (status & $past(status)) == $past(status);
  endproperty
  a_ara: assert property (p_ara) else $error("alert response wrong");
endmodule
bind pefc_cmd_core pefc_cmd_core_checker #(.SW(SW), .NPH(NPH)) u_chk (
  .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_read(cmd_read),
  .cmd_has_data(cmd_has_data), .cmd_wdata(cmd_wdata), .ara_read(ara_read), .rsp_ack(rsp_ack),
  .rsp_rdata(rsp_rdata), .phase_ready(phase_ready), .phase_selected(phase_selected),
  .fault_src(fault_src), .smbalert_n(smbalert_n), .status(status), .cml_invalid(cml_invalid),
  .lockout_active(lockout_active));
`default_nettype wire

// ### tb/pefc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pefc_host_model (
  input  wire logic       clk,
  input  wire logic       rsp_valid,
  input  wire logic       rsp_ack,
  input  wire logic [7:0] rsp_rdata,
  output var  logic       cmd_valid,
  output var  logic [7:0] cmd_code,
  output var  logic       cmd_read,
  output var  logic       cmd_has_data,
  output var  logic [7:0] cmd_wdata,
  output var  logic       ara_read
);
  initial begin
    {cmd_valid, cmd_code, cmd_read, cmd_has_data, cmd_wdata, ara_read} = 20'h0;
  end
  // One cycle command; released fields turn to garbage
  task automatic xfer(input logic [7:0] c, input logic rd, input logic [7:0] wd, output logic [9:0] r);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_read = rd;
    cmd_has_data = !rd && c != 8'h03;
    cmd_wdata = wd;
    @(negedge clk);
    r = {rsp_valid, rsp_ack, rsp_rdata};
    cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~wd;
  endtask
  task automatic ara;
    @(negedge clk);
    ara_read = 1'b1;
    @(negedge clk);
    ara_read = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/test_pefc_cmd_core.sv
`timescale 1ns/10ps
`default_nettype none
module test_pefc_cmd_core;
  logic clk, arst_n, pin, power_present, phase_ready, strap, latch;
  logic cmd_valid, cmd_read, cmd_has_data, ara_read, rsp_valid, rsp_ack;
  logic convert_en, ramp_down, lockout_active, smbalert_n, cml_invalid, phase_selected;
  logic [7:0] cmd_code, cmd_wdata, rsp_rdata, run_cmd, stagger, fault_src, status, my_phase;
  logic [15:0] hold, ramp;
  int fails = 0;
  int comparisons = 0;
  pefc_cmd_core dut (
    .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_read(cmd_read),
    .cmd_has_data(cmd_has_data), .cmd_wdata(cmd_wdata), .ara_read(ara_read), .rsp_valid(rsp_valid),
    .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata), .run_cmd(run_cmd), .enable_lockout_pin(pin),
    .power_present(power_present), .phase_ready(phase_ready), .sense_return_follower_strap(strap),
    .stagger_position_config(stagger), .turn_off_hold_time(hold), .turn_off_ramp_time(ramp),
    .fault_src(fault_src), .fault_latch_off(latch), .convert_en(convert_en), .ramp_down(ramp_down),
    .lockout_active(lockout_active), .smbalert_n(smbalert_n), .status(status),
    .cml_invalid(cml_invalid), .phase_selected(phase_selected), .my_phase(my_phase));
  pefc_host_model host (
    .clk(clk), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_read(cmd_read), .cmd_has_data(cmd_has_data), .cmd_wdata(cmd_wdata),
    .ara_read(ara_read));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude;
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmd(input logic [7:0] c, input logic rd, input logic [7:0] wd, input logic a, input logic [7:0] d);
    logic [9:0] r;
    host.xfer(c, rd, wd, r);
    chk(r, {1'b1, a, d});
  endtask
  task automatic t_reset;
    chk(my_phase, 8'h00);
    cmd(8'h02, 1'b1, 8'h00, 1'b1, 8'h17);
    cmd(8'h04, 1'b1, 8'h00, 1'b1, 8'hFF);
    cmd(8'h02, 1'b0, 8'hF7, 1'b0, 8'h00);
    w(1);
    chk({cml_invalid, smbalert_n}, 2'b10);
    cmd(8'h02, 1'b1, 8'h00, 1'b1, 8'h17);
    cmd(8'h03, 1'b1, 8'h00, 1'b0, 8'h00);
    cmd(8'h03, 1'b0, 8'h00, 1'b0, 8'h00);
    phase_ready = 1'b1;
    cmd(8'h03, 1'b0, 8'h00, 1'b1, 8'h00);
    chk({cml_invalid, smbalert_n}, 2'b01);
    cmd(8'h01, 1'b0, 8'h80, 1'b0, 8'h00);
    chk({cml_invalid, smbalert_n}, 2'b01);
  endtask
  task automatic t_sources;
    logic [7:0] t [9] = '{8'h01, 8'hC0, 8'hC3, 8'hBD, 8'hB8, 8'hA9, 8'hAC, 8'hFC, 8'hFF};
    for (int i = 0; i < 9; i++) begin
      cmd(8'h02, 1'b0, {3'h0, t[i][7:3]}, 1'b1, 8'h00);
      pin = t[i][2];
      run_cmd = {t[i][1], 7'h00};
      w(6);
      chk(convert_en, t[i][0]);
      chk(lockout_active, t[i][7] & t[i][5] & t[i][4]);
    end
  endtask
  task automatic t_turnoff(input logic d);
    int n;
    int rc;
    n = 0;
    rc = 0;
    cmd(8'h02, 1'b0, {7'h0B, d}, 1'b1, 8'h00);
    pin = 1'b1;
    w(6);
    pin = 1'b0;
    while (convert_en === 1'b1 && n < 30) begin
      w(1);
      n++;
      rc += ramp_down;
    end
    if (n == 30) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, convert_en, 1'b0);
      conclude;
    end
    chk(rc[9:0], d ? 10'd0 : 10'd4);
    chk(n[9:0], d ? 10'd3 : 10'd10);
  endtask
  task automatic t_fault;
    fault_src = 8'h01;
    w(3);
    chk({smbalert_n, status}, 9'h001);
    host.ara;
    w(1);
    chk({smbalert_n, status}, 9'h101);
    w(3);
    chk(smbalert_n, 1'b1);
    fault_src = 8'h03;
    w(3);
    chk(smbalert_n, 1'b0);
    host.ara;
    cmd(8'h03, 1'b0, 8'h00, 1'b1, 8'h00);
    chk({smbalert_n, status}, 9'h103);
    w(1);
    chk(smbalert_n, 1'b0);
    fault_src = 8'h00;
    cmd(8'h03, 1'b0, 8'h00, 1'b1, 8'h00);
    chk({smbalert_n, status}, 9'h100);
  endtask
  task automatic t_phase;
    logic [9:0] r;
    cmd(8'h04, 1'b0, 8'h01, 1'b1, 8'h00);
    fault_src = 8'h10;
    w(3);
    fault_src = 8'h00;
    chk(phase_selected, 1'b0);
    host.xfer(8'h03, 1'b0, 8'h00, r);
    chk(status, 8'h10);
    cmd(8'h04, 1'b0, 8'h05, 1'b0, 8'h00);
    cmd(8'h04, 1'b1, 8'h00, 1'b1, 8'h01);
    cmd(8'h04, 1'b0, 8'h00, 1'b1, 8'h00);
    cmd(8'h03, 1'b0, 8'h00, 1'b1, 8'h00);
    chk({phase_selected, status}, 9'h100);
  endtask
  task automatic t_latch;
    cmd(8'h02, 1'b0, 8'h00, 1'b1, 8'h00);
    w(6);
    fault_src = 8'h04;
    latch = 1'b1;
    w(4);
    latch = 1'b0;
    cmd(8'h03, 1'b0, 8'h00, 1'b1, 8'h00);
    w(4);
    chk({convert_en, smbalert_n, status}, 10'h004);
  endtask
  task automatic t_follower;
    fault_src = 8'h00;
    strap = 1'b1;
    arst_n = 1'b0;
    w(2);
    arst_n = 1'b1;
    w(2);
    chk(my_phase, 8'h02);
    chk({smbalert_n, convert_en, status}, 10'h200);
    cmd(8'h04, 1'b1, 8'h00, 1'b1, 8'hFF);
  endtask
  initial begin
    {arst_n, pin, phase_ready, strap, latch, run_cmd, fault_src} = 21'h0;
    power_present = 1'b1;
    stagger = 8'h02;
    hold = 16'h0003;
    ramp = 16'h0004;
    w(20);
    arst_n = 1'b1;
    w(2);
    t_reset;
    t_sources;
    t_turnoff(1'b0);
    t_turnoff(1'b1);
    t_fault;
    t_phase;
    t_latch;
    t_follower;
    conclude;
  end
endmodule
`default_nettype wire
